// ### verilog/adcc_ctrl.sv
// host-side controller: starts conversions and reads results over the converter pins
`timescale 1ns/100ps
`include "adcc_map.svh"

// Operation
// R1: read_not_write low converts, high reads
// R2: hold start pulse at least 300 ns
// R3: status high throughout a conversion
// R4: device resolves eight bits MSB first
// R5: device times bits itself, no clock
// R6: status falls at end of conversion
// R7: data drives only on selected read
// R8: raising selects ends read, releases bus
// R9: no data drive during conversion
// R10: starts during conversion are ignored
// R11: conversion cannot be aborted or restarted
// R12: bipolar select sampled at start, high bipolar
// R13: unipolar needs bipolar select low at start
// R14: coding select at start; bipolar 1 twos
// R15: both selects low enable; else nothing
// R16: selects held low repeat conversions
// R17: unipolar coding 0 straight, 1 twos
// R18: status high for the conversion duration
module adcc_ctrl (
  input  wire logic       sys_clk_i,         // system clock, 20 MHz
  input  wire logic       rst_i,             // async reset, active high
  input  wire logic       conv_req_i,        // user: request a conversion (level, taken when ready)
  input  wire logic       bipolar_i,         // user: bipolar range wanted
  input  wire logic       twos_i,            // user: two's complement coding wanted
  input  wire logic       read_req_i,        // user: request a result read
  output logic            ready_o,           // user: controller idle, requests taken
  output logic            conv_done_o,       // user: conversion finished, pulse
  output logic            rd_valid_o,        // user: result valid, pulse
  output logic [7:0]      rd_data_o,         // user: last read result
  output logic            timeout_o,         // user: status never fell, pulse
  output logic            chip_en_n_o,       // pin: chip enable, active low
  output logic            chip_sel_n_o,      // pin: chip select, active low
  output logic            read_not_write_o,  // pin: high read, low write
  output logic            bipolar_unipolar_select_o, // pin: range select
  output logic            format_o,          // pin: output coding select
  input  wire logic       status_i,          // pin: converter busy
  input  wire logic [7:0] data_i             // pin: converter data bus
);
  // ****************************************************************
  // pin synchroniser
  // ****************************************************************
  adcc_sync_if sync ();

  adcc_pin_sync u_sync (
    .sys_clk_i (sys_clk_i),
    .rst_i     (rst_i),
    .status_i  (status_i),
    .data_i    (data_i),
    .sync      (sync)
  );

  // ****************************************************************
  // sequencer
  // ****************************************************************
  adcc_pkg::adcc_state_type state_reg, state_next;
  logic [`ADCC_CNT_W-1:0]   cnt_reg, cnt_next;
  logic                     seen_reg, seen_next;
  logic                     ce_n_reg, ce_n_next;
  logic                     cs_n_reg, cs_n_next;
  logic                     rnw_reg, rnw_next;
  logic                     rng_reg, rng_next;
  logic                     fmt_reg, fmt_next;
  logic [7:0]               data_reg, data_next;
  logic                     done_reg, done_next;
  logic                     valid_reg, valid_next;
  logic                     tmo_reg, tmo_next;

  always_comb begin
    state_next = state_reg;
    cnt_next   = cnt_reg;
    seen_next  = seen_reg;
    ce_n_next  = ce_n_reg;
    cs_n_next  = cs_n_reg;
    rnw_next   = rnw_reg;
    rng_next   = rng_reg;
    fmt_next   = fmt_reg;
    data_next  = data_reg;
    done_next  = 1'b0;
    valid_next = 1'b0;
    tmo_next   = 1'b0;
    unique case (state_reg)
      adcc_pkg::ST_IDLE: begin
        ce_n_next = 1'b1;   // [R15]
        cs_n_next = 1'b1;
        rnw_next  = 1'b1;
        cnt_next  = '0;
        // no new access while the converter still reports busy
        if (!sync.busy) begin   // [R10] [R11]
          if (conv_req_i) begin
            rng_next   = bipolar_i;   // [R12] [R13]
            fmt_next   = twos_i;      // [R14] [R17]
            rnw_next   = 1'b0;        // [R1]
            state_next = adcc_pkg::ST_SETUP;
          end else if (read_req_i) begin
            rnw_next   = 1'b1;        // [R1]
            state_next = adcc_pkg::ST_SETUP;
          end
        end
      end
      adcc_pkg::ST_SETUP: begin
        // select lines settle before the strobe falls
        if (cnt_reg == `ADCC_CNT_W'(`ADCC_SETUP_CYC - 1)) begin
          cnt_next  = '0;
          ce_n_next = 1'b0;
          cs_n_next = 1'b0;
          state_next = rnw_reg ? adcc_pkg::ST_RPULSE : adcc_pkg::ST_WPULSE;
        end else begin
          cnt_next = cnt_reg + `ADCC_CNT_W'(1);
        end
      end
      adcc_pkg::ST_WPULSE: begin
        if (sync.rise) begin
          seen_next = 1'b1;
        end
        // short pulse so a held strobe cannot chain conversions
        if (cnt_reg == `ADCC_CNT_W'(`ADCC_START_CYC - 1)) begin   // [R2] [R16]
          cnt_next   = '0;
          ce_n_next  = 1'b1;
          cs_n_next  = 1'b1;
          state_next = adcc_pkg::ST_WBUSY;
        end else begin
          cnt_next = cnt_reg + `ADCC_CNT_W'(1);
        end
      end
      adcc_pkg::ST_WBUSY: begin
        rnw_next = 1'b1;
        cnt_next = cnt_reg + `ADCC_CNT_W'(1);
        if (sync.rise || sync.busy) begin
          seen_next = 1'b1;   // [R3]
        end
        if (seen_reg && sync.fall) begin   // [R6] [R18]
          done_next  = 1'b1;
          seen_next  = 1'b0;
          state_next = adcc_pkg::ST_WDONE;
        end else if (!seen_reg && !sync.busy &&
                     cnt_reg >= `ADCC_CNT_W'(`ADCC_BUSY_WAIT_CYC)) begin
          // very fast device: status already dropped before seen
          done_next  = 1'b1;
          state_next = adcc_pkg::ST_WDONE;
        end else if (cnt_reg == `ADCC_CNT_W'(`ADCC_CONV_TMO_CYC)) begin
          tmo_next   = 1'b1;
          seen_next  = 1'b0;
          state_next = adcc_pkg::ST_WDONE;
        end
      end
      adcc_pkg::ST_WDONE: begin
        cnt_next   = '0;
        state_next = adcc_pkg::ST_IDLE;
      end
      adcc_pkg::ST_RPULSE: begin
        // reads only start when not busy, so the bus is driven [R7] [R9]
        // hold long enough for the pin synchroniser to pass the new byte
        if (cnt_reg == `ADCC_CNT_W'(`ADCC_READ_CYC - 1)) begin
          data_next  = sync.data;   // [R4]
          cnt_next   = '0;
          state_next = adcc_pkg::ST_RLATCH;
        end else begin
          cnt_next = cnt_reg + `ADCC_CNT_W'(1);
        end
      end
      adcc_pkg::ST_RLATCH: begin
        ce_n_next  = 1'b1;   // [R8]
        cs_n_next  = 1'b1;
        valid_next = 1'b1;
        state_next = adcc_pkg::ST_IDLE;
      end
      default: begin
        state_next = adcc_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      state_reg <= adcc_pkg::ST_IDLE;
      cnt_reg   <= '0;
      seen_reg  <= 1'b0;
      ce_n_reg  <= 1'b1;
      cs_n_reg  <= 1'b1;
      rnw_reg   <= 1'b1;
      rng_reg   <= 1'b0;
      fmt_reg   <= 1'b0;
      data_reg  <= 8'h00;
      done_reg  <= 1'b0;
      valid_reg <= 1'b0;
      tmo_reg   <= 1'b0;
    end else begin
      state_reg <= state_next;
      cnt_reg   <= cnt_next;
      seen_reg  <= seen_next;
      ce_n_reg  <= ce_n_next;
      cs_n_reg  <= cs_n_next;
      rnw_reg   <= rnw_next;
      rng_reg   <= rng_next;
      fmt_reg   <= fmt_next;
      data_reg  <= data_next;
      done_reg  <= done_next;
      valid_reg <= valid_next;
      tmo_reg   <= tmo_next;
    end
  end

  // ****************************************************************
  // outputs
  // ****************************************************************
  assign ready_o                   = (state_reg == adcc_pkg::ST_IDLE) & ~sync.busy;
  assign conv_done_o               = done_reg;
  assign rd_valid_o                = valid_reg;
  assign rd_data_o                 = data_reg;
  assign timeout_o                 = tmo_reg;
  assign chip_en_n_o               = ce_n_reg;
  assign chip_sel_n_o              = cs_n_reg;
  assign read_not_write_o          = rnw_reg;
  assign bipolar_unipolar_select_o = rng_reg;
  assign format_o                  = fmt_reg;
endmodule : adcc_ctrl

// ### verilog/adcc_map.svh
// timing counts and pin-level constants for the converter bus controller
`ifndef ADCC_MAP_SVH
`define ADCC_MAP_SVH
`define ADCC_CLK_PERIOD_NS   50
`define ADCC_START_MIN_NS    300
`define ADCC_START_CYC       ((`ADCC_START_MIN_NS + `ADCC_CLK_PERIOD_NS - 1) / `ADCC_CLK_PERIOD_NS)
`define ADCC_SETUP_CYC       2
`define ADCC_READ_CYC        5
`define ADCC_BUSY_WAIT_CYC   8
`define ADCC_CONV_TIME_NS    10000
`define ADCC_CONV_TMO_CYC    (2 * `ADCC_CONV_TIME_NS / `ADCC_CLK_PERIOD_NS)
`define ADCC_CNT_W           10
`endif

// ### verilog/adcc_pkg.sv
// types of the converter bus controller
package adcc_pkg;
  typedef enum logic [6:0] {
    ST_IDLE   = 7'b0000001,
    ST_SETUP  = 7'b0000010,
    ST_WPULSE = 7'b0000100,
    ST_WBUSY  = 7'b0001000,
    ST_WDONE  = 7'b0010000,
    ST_RPULSE = 7'b0100000,
    ST_RLATCH = 7'b1000000
  } adcc_state_type;
endpackage : adcc_pkg

// ### verilog/adcc_sync_if.sv
// carrier between the controller and its pin synchroniser
`timescale 1ns/100ps
interface adcc_sync_if;
  logic       busy;
  logic [7:0] data;
  logic       rise;
  logic       fall;
  modport src (output busy, output data, output rise, output fall);
  modport dst (input busy, input data, input rise, input fall);
endinterface : adcc_sync_if

// ### verilog/adcc_pin_sync.sv
// three-stage synchroniser for the status and data pins
`timescale 1ns/100ps
module adcc_pin_sync (
  input  wire logic       sys_clk_i,    // system clock
  input  wire logic       rst_i,        // async reset
  input  wire logic       status_i,     // status pin
  input  wire logic [7:0] data_i,       // data bus pins
  adcc_sync_if.src        sync          // synchronised view
);
  logic [8:0] s1_reg, s2_reg, s3_reg, val_reg;
  logic [8:0] val_next;

  always_comb begin
    val_next = val_reg;
    // accept a level only once the last two stages agree
    for (int i = 0; i < 9; i++) begin
      if (s2_reg[i] == s3_reg[i]) begin
        val_next[i] = s3_reg[i];
      end
    end
  end

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      s1_reg  <= 9'h000;
      s2_reg  <= 9'h000;
      s3_reg  <= 9'h000;
      val_reg <= 9'h000;
    end else begin
      s1_reg  <= {status_i, data_i};
      s2_reg  <= s1_reg;
      s3_reg  <= s2_reg;
      val_reg <= val_next;
    end
  end

  assign sync.busy = val_reg[8];
  assign sync.data = val_reg[7:0];
  assign sync.rise = val_next[8] & ~val_reg[8];
  assign sync.fall = ~val_next[8] & val_reg[8];
endmodule : adcc_pin_sync

// ### tb/adcc_dev_model.sv
// behavioural converter seen from its pins
`timescale 1ns/100ps
module adcc_dev_model #(
  parameter int CONV_NS = 2000  // shortened self-timed conversion
) (
  input  wire logic       chip_en_n_i,  // chip enable, active low
  input  wire logic       chip_sel_n_i, // chip select, active low
  input  wire logic       rnw_i,        // high read, low convert
  input  wire logic       rng_i,        // range select
  input  wire logic       fmt_i,        // coding select
  input  wire logic [7:0] level_i,      // analog input as a code
  input  wire logic       mute_i,       // drop every start
  output logic            status_o,     // busy
  output logic [7:0]      data_o        // data bus
);
  logic [7:0] code_reg;
  logic [7:0] acc;
  logic       fmt_l;
  logic       rng_l;
  logic       sel;
  assign sel = !chip_en_n_i && !chip_sel_n_i;
  // released bus shows the inverse so a stale byte never passes
  assign data_o = (sel && rnw_i && !status_o) ? code_reg : ~code_reg;
  initial begin
    status_o = 1'b0;
    code_reg = 8'h00;
    forever begin
      @(posedge sel);
      if (!rnw_i && !status_o) begin
        rng_l = rng_i;
        fmt_l = fmt_i;
        #299;
        // strobe too short, or converter muted: start dropped
        if (sel && !rnw_i && !mute_i) begin
          status_o = 1'b1;
          acc = 8'h00;
          for (int b = 7; b >= 0; b--) begin
            #(CONV_NS / 8);
            acc[b] = 1'b1;
            if (acc > level_i) acc[b] = 1'b0;
          end
          code_reg = fmt_l ? acc ^ 8'h80 : acc;
          status_o = 1'b0;
        end
      end
    end
  end
endmodule : adcc_dev_model

// ### tb/adcc_ctrl_assertions.sv
// pin-level checks on the converter bus controller
`timescale 1ns/100ps
module adcc_ctrl_chk (
  input wire logic sys_clk_i,                 // system clock
  input wire logic rst_i,                     // async reset
  input wire logic chip_en_n_o,               // chip enable pin
  input wire logic chip_sel_n_o,              // chip select pin
  input wire logic read_not_write_o,          // access type pin
  input wire logic bipolar_unipolar_select_o, // range pin
  input wire logic format_o,                  // coding pin
  input wire logic status_i,                  // busy pin
  input wire logic conv_done_o,               // done pulse
  input wire logic rd_valid_o                 // read pulse
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);
  a_sel_pair_move: assert property (chip_en_n_o == chip_sel_n_o) else $error("selects split");
  a_write_pulse_len: assert property ($fell(chip_en_n_o) && !read_not_write_o |->
    (!chip_en_n_o && !read_not_write_o)[*6] ##1 chip_en_n_o) else $error("bad start strobe");
  a_rnw_held_sel: assert property (!chip_en_n_o && !$past(chip_en_n_o) |-> $stable(read_not_write_o))
    else $error("access type moved while selected");
  a_no_read_busy: assert property ($fell(chip_en_n_o) && read_not_write_o |-> !status_i)
    else $error("read during conversion");
  a_mode_hold: assert property (status_i |-> $stable(bipolar_unipolar_select_o) && $stable(format_o))
    else $error("mode pins moved while busy");
  a_done_after_fall: assert property ($fell(status_i) |-> ##[1:8] conv_done_o) else $error("done missing");
  a_no_start_busy: assert property (status_i && $past(status_i, 2) |-> chip_en_n_o)
    else $error("select during conversion");
  a_read_cycle: assert property ($fell(chip_en_n_o) && read_not_write_o |->
    (!chip_en_n_o)[*6] ##1 (chip_en_n_o && rd_valid_o)) else $error("bad read cycle");
endmodule : adcc_ctrl_chk
bind adcc_ctrl adcc_ctrl_chk u_chk (
  .sys_clk_i                 (sys_clk_i),
  .rst_i                     (rst_i),
  .chip_en_n_o               (chip_en_n_o),
  .chip_sel_n_o              (chip_sel_n_o),
  .read_not_write_o          (read_not_write_o),
  .bipolar_unipolar_select_o (bipolar_unipolar_select_o),
  .format_o                  (format_o),
  .status_i                  (status_i),
  .conv_done_o               (conv_done_o),
  .rd_valid_o                (rd_valid_o)
);

// ### tb/tb_top.sv
// self-checking bench: controller against a converter model
`timescale 1ns/100ps
module tb_top;
  logic       sys_clk_i = 1'b0;
  logic       rst_i = 1'b1;
  logic       conv_req_i = 1'b0;
  logic       read_req_i = 1'b0;
  logic       bipolar_i = 1'b0;
  logic       twos_i = 1'b0;
  logic       ready_o, conv_done_o, rd_valid_o, timeout_o, status_i;
  logic       chip_en_n_o, chip_sel_n_o, read_not_write_o, rng_o, format_o;
  logic [7:0] rd_data_o, data_i;
  logic [7:0] level = 8'h00;
  logic       mute = 1'b0;
  logic [9:0] r;
  int         n_mismatch = 0;
  int         check_count = 0;
  always #25 sys_clk_i = ~sys_clk_i;
  adcc_ctrl dut (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .conv_req_i(conv_req_i), .bipolar_i(bipolar_i),
    .twos_i(twos_i), .read_req_i(read_req_i), .ready_o(ready_o), .conv_done_o(conv_done_o),
    .rd_valid_o(rd_valid_o), .rd_data_o(rd_data_o), .timeout_o(timeout_o), .chip_en_n_o(chip_en_n_o),
    .chip_sel_n_o(chip_sel_n_o), .read_not_write_o(read_not_write_o), .bipolar_unipolar_select_o(rng_o),
    .format_o(format_o), .status_i(status_i), .data_i(data_i));
  adcc_dev_model #(.CONV_NS(2000)) u_dev (.chip_en_n_i(chip_en_n_o), .chip_sel_n_i(chip_sel_n_o),
    .rnw_i(read_not_write_o), .rng_i(rng_o), .fmt_i(format_o), .level_i(level), .mute_i(mute),
    .status_o(status_i), .data_o(data_i));
  function automatic logic [7:0] exp_code(input logic [7:0] raw, input logic twos);
    return twos ? {~raw[7], raw[6:0]} : raw;
  endfunction : exp_code
  task automatic cmp(input string what, input logic [7:0] exp, input logic [7:0] got);
    check_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : cmp
  task automatic wait_ready;
    for (int k = 0; k < 600 && ready_o !== 1'b1; k++) @(negedge sys_clk_i);
  endtask : wait_ready
  task automatic convert(input logic b, input logic t, input logic [7:0] l);
    int hi;
    int tmo;
    hi = 0;
    tmo = 0;
    level = l;
    wait_ready();
    conv_req_i = 1'b1;
    bipolar_i = b;
    twos_i = t;
    @(negedge sys_clk_i);
    conv_req_i = 1'b0;
    // flip the wanted modes: pins must keep the values taken at accept
    bipolar_i = ~b;
    twos_i = ~t;
    for (int k = 0; k < 600 && conv_done_o !== 1'b1; k++) begin
      @(negedge sys_clk_i);
      if (status_i === 1'b1) hi++;
      if (timeout_o === 1'b1) tmo++;
    end
    cmp("done pulse", 8'h01, {7'h00, conv_done_o});
    cmp("timeout pulses", 8'h00, tmo[7:0]);
    cmp("busy cycles", 8'h28, hi[7:0]);
    cmp("range pin", {7'h00, b}, {7'h00, rng_o});
    cmp("coding pin", {7'h00, t}, {7'h00, format_o});
  endtask : convert
  task automatic read_check(input logic [7:0] exp);
    wait_ready();
    read_req_i = 1'b1;
    @(negedge sys_clk_i);
    read_req_i = 1'b0;
    for (int k = 0; k < 50 && rd_valid_o !== 1'b1; k++) @(negedge sys_clk_i);
    cmp("read valid", 8'h01, {7'h00, rd_valid_o});
    cmp("result", exp, rd_data_o);
  endtask : read_check
  task automatic summarize;
    $display("comparisons %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : summarize
  initial begin
    void'($urandom(31390));
    repeat (5) @(negedge sys_clk_i);
    rst_i = 1'b0;
    // all four range/coding pairs on codes around mid-scale
    for (int m = 0; m < 4; m++) begin
      convert(m[1], m[0], 8'h7f + m[7:0]);
      read_check(exp_code(8'h7f + m[7:0], m[0]));
    end
    convert(1'b0, 1'b0, 8'hff);
    read_check(8'hff);
    convert(1'b1, 1'b1, 8'h00);
    read_check(8'h80);
    // back to back: the second result must replace the first
    convert(1'b0, 1'b1, 8'h35);
    convert(1'b1, 1'b0, 8'hca);
    read_check(8'hca);
    repeat (8) begin
      r = 10'($urandom);
      convert(r[8], r[9], r[7:0]);
      read_check(exp_code(r[7:0], r[9]));
    end
    // silent converter: status never rises, controller must still finish
    mute = 1'b1;
    wait_ready();
    conv_req_i = 1'b1;
    @(negedge sys_clk_i);
    conv_req_i = 1'b0;
    for (int k = 0; k < 50 && conv_done_o !== 1'b1; k++) @(negedge sys_clk_i);
    cmp("fallback done", 8'h01, {7'h00, conv_done_o});
    mute = 1'b0;
    convert(1'b0, 1'b0, 8'h5a);
    read_check(8'h5a);
    summarize();
  end
  initial begin
    repeat (20000) @(posedge sys_clk_i);
    n_mismatch++;
    summarize();
  end
endmodule : tb_top
